// ===== hdl/mmx_monitor_mux.sv
// Serial command decoder and monitor mux control register.
`timescale 1ns/100ps
`include "mmx_params.svh"

// What this block does
// - Monitor pin is undriven while enable is zero, also at reset.
// - Command 0111 0101 writes; five don't-cares, enable, select, trailing byte.
// - Enable bit one connects the chosen source; enable resets to zero.
// - Ten-bit select is the source address, resetting to zero.
// - 11_0000_cccc routes channel voltage; 00_0000_cccc routes sense voltage.
// - 10_00nn_0000 picks reference low, supply, reference or temperature.
// - A sense code puts that channel's load sense voltage on the pin.
// - Read back the mux register with command 29.
// - Read data shifts out on the following frame, not the read frame.
// - Each channel holds its own toggle-or-dither selection.
// - Without CRC a frame may be only 24 bits long.
// - Readback uses the write layout with zeros in the trailing byte.
module mmx_monitor_mux
(
  // System clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // Serial link pins from the host
  input  wire logic                  spi_sck,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_sdi,
  output logic                       spi_sdo,
  // Monitor pin routing to the analog mux
  output logic                       mon_oe,
  output mmx_pkg::mmx_route_type     mon_route,
  // Per-channel toggle or dither selection
  output logic [15:0]                td_mode
);

  logic [2:0]              pins_sync;
  logic                    sck_prev_reg;
  logic                    sck_prev_next;
  mmx_pkg::mmx_state_type  state_reg;
  mmx_pkg::mmx_state_type  state_next;
  logic [31:0]             shift_reg;
  logic [31:0]             shift_next;
  logic [5:0]              count_reg;
  logic [5:0]              count_next;
  logic [23:0]             out_reg;
  logic [23:0]             out_next;
  logic [23:0]             pend_reg;
  logic [23:0]             pend_next;
  mmx_pkg::mmx_ctrl_type   ctrl_reg;
  mmx_pkg::mmx_ctrl_type   ctrl_next;
  logic [15:0]             td_reg;
  logic [15:0]             td_next;
  logic                    sdo_reg;
  logic                    sdo_next;
  mmx_pkg::mmx_route_type  route_reg;
  mmx_pkg::mmx_route_type  route_next;
  logic                    oe_reg;
  logic                    oe_next;
  logic                    sck_rise;
  logic                    sck_fall;
  logic [23:0]             frame;

  mmx_sync u_sync
  (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({spi_cs_n, spi_sck, spi_sdi}),
    .sync_out (pins_sync)
  );

  // ------------------------------------------------------------------
  // Select code decoding
  // ------------------------------------------------------------------
  function automatic mmx_pkg::mmx_route_type decode_select
  (
    input mmx_pkg::mmx_ctrl_type c
  );
    mmx_pkg::mmx_route_type r;
    r.drive   = 1'b0;
    r.kind    = mmx_pkg::MMX_SRC_NONE;
    r.channel = c.select[3:0];
    r.node    = c.select[5:4];
    if (c.select[9:4] == 6'h30)
      r.kind = mmx_pkg::MMX_SRC_VOUT;
    else if (c.select[9:4] == 6'h00)
      r.kind = mmx_pkg::MMX_SRC_SENSE;
    else if (c.select[9:6] == 4'h8 && c.select[3:0] == 4'h0)
      r.kind = mmx_pkg::MMX_SRC_NODE;
    // drive only when enabled and the code is listed
    r.drive = c.enable && (r.kind != mmx_pkg::MMX_SRC_NONE);
    return r;
  endfunction : decode_select

  // ------------------------------------------------------------------
  // Serial frame engine
  // ------------------------------------------------------------------
  always_comb
  begin
    sck_prev_next = pins_sync[1];
    sck_rise      = pins_sync[1] && !sck_prev_reg;
    sck_fall      = !pins_sync[1] && sck_prev_reg;
    state_next    = state_reg;
    shift_next    = shift_reg;
    count_next    = count_reg;
    out_next      = out_reg;
    pend_next     = pend_reg;
    ctrl_next     = ctrl_reg;
    td_next       = td_reg;
    sdo_next      = sdo_reg;
    // accept either a 24-bit or a 32-bit frame
    frame = (count_reg == `MMX_FRAME_LONG) ? shift_reg[31:8]
                                           : shift_reg[23:0];
    case (state_reg)
      mmx_pkg::MMX_ST_IDLE:
      begin
        if (!pins_sync[2])
        begin
          state_next = mmx_pkg::MMX_ST_SHIFT;
          count_next = 6'h00;
          // last frame's read data goes out in this frame
          out_next   = pend_reg;
          pend_next  = 24'h000000;
          sdo_next   = pend_reg[23];
        end
      end
      mmx_pkg::MMX_ST_SHIFT:
      begin
        if (pins_sync[2])
          state_next = mmx_pkg::MMX_ST_EXEC;
        else if (sck_rise && count_reg != `MMX_FRAME_LONG)
        begin
          shift_next = {shift_reg[30:0], pins_sync[0]};
          count_next = count_reg + 6'h01;
        end
        else if (sck_fall)
        begin
          out_next = {out_reg[22:0], 1'b0};
          sdo_next = out_reg[22];
        end
      end
      mmx_pkg::MMX_ST_EXEC:
      begin
        state_next = mmx_pkg::MMX_ST_IDLE;
        sdo_next   = 1'b0;
        // Frames of other than 24 or 32 bits are dropped whole; past 32 bits only the first 32 count.
        if (count_reg == `MMX_FRAME_SHORT || count_reg == `MMX_FRAME_LONG)
        begin
          case (frame[23:16])
            `MMX_CMD_MUX_WRITE:
              ctrl_next = mmx_pkg::mmx_ctrl_type'(frame[10:0]);
            // readback in write layout, zero tail byte
            `MMX_CMD_MUX_READ:
              pend_next = {`MMX_CMD_MUX_WRITE,
                           16'(ctrl_reg) & `MMX_CTRL_MASK};
            `MMX_CMD_TD_WRITE:
              td_next = frame[15:0];
            `MMX_CMD_TD_READ:
              pend_next = {`MMX_CMD_TD_WRITE, td_reg};
            default:
              ctrl_next = ctrl_reg;
          endcase
        end
      end
      default:
        state_next = mmx_pkg::MMX_ST_IDLE;
    endcase
    route_next = decode_select(ctrl_reg);
    oe_next    = route_next.drive;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sck_prev_reg <= 1'b0;
      state_reg    <= mmx_pkg::MMX_ST_IDLE;
      shift_reg    <= 32'h00000000;
      count_reg    <= 6'h00;
      out_reg      <= 24'h000000;
      pend_reg     <= 24'h000000;
      // enable and select clear at reset
      ctrl_reg     <= mmx_pkg::mmx_ctrl_type'(11'(`MMX_CTRL_RESET));
      td_reg       <= `MMX_TD_RESET;
      sdo_reg      <= 1'b0;
      route_reg    <= '{1'b0, mmx_pkg::MMX_SRC_NONE, 4'h0, 2'h0};
      oe_reg       <= 1'b0;
    end
    else
    begin
      sck_prev_reg <= sck_prev_next;
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      count_reg    <= count_next;
      out_reg      <= out_next;
      pend_reg     <= pend_next;
      ctrl_reg     <= ctrl_next;
      td_reg       <= td_next;
      sdo_reg      <= sdo_next;
      route_reg    <= route_next;
      oe_reg       <= oe_next;
    end
  end

  assign spi_sdo   = sdo_reg;
  assign mon_oe    = oe_reg;
  assign mon_route = route_reg;
  assign td_mode   = td_reg;

endmodule : mmx_monitor_mux

// ===== inc/mmx_params.svh
// Constants for the monitor mux select control block.
`ifndef MMX_PARAMS_SVH
`define MMX_PARAMS_SVH

`define MMX_CMD_MUX_WRITE   8'h75
`define MMX_CMD_MUX_READ    8'h1d
`define MMX_CMD_TD_WRITE    8'h0b
`define MMX_CMD_TD_READ     8'h1b
`define MMX_ENABLE_BIT      10
`define MMX_CTRL_RESET      16'h0000
`define MMX_CTRL_MASK       16'h07ff
`define MMX_TD_RESET        16'h0000
`define MMX_FRAME_SHORT     6'h18
`define MMX_FRAME_LONG      6'h20
`define MMX_NUM_CHANNELS    16
`define MMX_SYS_CLK_MHZ     200
`define MMX_SYNC_STAGES     2

`endif

// ===== inc/mmx_pkg.sv
// Types for the monitor mux select control block.
package mmx_pkg;

  typedef enum logic [3:0] {
    MMX_SRC_NONE   = 4'h1,
    MMX_SRC_VOUT   = 4'h2,
    MMX_SRC_SENSE  = 4'h4,
    MMX_SRC_NODE   = 4'h8
  } mmx_src_type;

  typedef enum logic [3:0] {
    MMX_ST_IDLE  = 4'h1,
    MMX_ST_SHIFT = 4'h2,
    MMX_ST_EXEC  = 4'h4,
    MMX_ST_HOLD  = 4'h8
  } mmx_state_type;

  typedef struct packed {
    logic       enable;
    logic [9:0] select;
  } mmx_ctrl_type;

  typedef struct packed {
    logic        drive;
    mmx_src_type kind;
    logic [3:0]  channel;
    logic [1:0]  node;
  } mmx_route_type;

endpackage : mmx_pkg

// ===== hdl/mmx_sync.sv
// Two-stage synchroniser for the serial link pins.
`timescale 1ns/100ps
module mmx_sync
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Pins in and synchronised levels out
  input  wire logic [2:0] async_in,
  output logic      [2:0] sync_out
);

  logic [2:0] stage1_reg;
  logic [2:0] stage1_next;
  logic [2:0] stage2_reg;
  logic [2:0] stage2_next;

  always_comb
  begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  // Select line idles high so it resets high, to avoid a false frame start.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stage1_reg <= 3'h4;
      stage2_reg <= 3'h4;
    end
    else
    begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;

endmodule : mmx_sync

// ===== verification/mmx_monitor_mux_sva.sv
// Assertion checker for the monitor mux control block.
`timescale 1ns/100ps
module mmx_monitor_mux_sva
(
  // Clock, reset and pins
  input wire logic                   sys_clk,
  input wire logic                   srst,
  input wire logic                   spi_sck,
  input wire logic                   spi_cs_n,
  input wire logic                   spi_sdo,
  input wire logic                   mon_oe,
  input wire mmx_pkg::mmx_route_type mon_route,
  input wire logic [15:0]            td_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_oe_drive; mon_oe == mon_route.drive; endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("drive flag differs from pin enable");
  property p_rst; $fell(srst) |-> !mon_oe && td_mode == 16'h0000
    && mon_route.kind == mmx_pkg::MMX_SRC_NONE; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not at defaults after reset");
  property p_node; mon_route.kind == mmx_pkg::MMX_SRC_NODE
    |-> mon_route.channel == 4'h0; endproperty
  a_node: assert property (p_node)
    else $error("internal node chosen with nonzero low nibble");
  property p_oe_src; mon_oe |-> mon_route.kind != mmx_pkg::MMX_SRC_NONE;
  endproperty
  a_oe_src: assert property (p_oe_src)
    else $error("pin driven with no source");
  property p_frame; (!spi_cs_n)[*8] |=> $stable(mon_route); endproperty
  a_frame: assert property (p_frame)
    else $error("routing changed inside a frame");
  property p_route; $changed(mon_route) |-> $past(spi_cs_n, 5); endproperty
  a_route: assert property (p_route)
    else $error("routing changed without frame end");
  property p_td; $changed(td_mode) |-> $past(spi_cs_n, 4); endproperty
  a_td: assert property (p_td)
    else $error("mode bits changed without frame end");
  property p_sdo; $rose(spi_sck) && !spi_cs_n |=> $stable(spi_sdo)[*3];
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("data out moved while clock high");
endmodule : mmx_monitor_mux_sva
bind mmx_monitor_mux mmx_monitor_mux_sva i_mmx_monitor_mux_sva
  (.sys_clk(sys_clk), .srst(srst), .spi_sck(spi_sck),
   .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo), .mon_oe(mon_oe),
   .mon_route(mon_route), .td_mode(td_mode));

// ===== verification/mmx_host.sv
// Serial host model that sends command frames.
`timescale 1ns/100ps
module mmx_host
(
  // Link pins
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = 32'h0;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi = tx[31 - i];
      #32 sck = 1'b1;
      rx = {rx[30:0], sdo};
      #32 sck = 1'b0;
    end
    #32 cs_n = 1'b1;
    // No pull on the line, so leave it at a changed level.
    sdi = ~sdi;
    #100;
  endtask : xfer
endmodule : mmx_host

// ===== verification/tb_mmx_monitor_mux.sv
// Self-checking bench for the monitor mux control block.
`timescale 1ns/100ps
module tb_mmx_monitor_mux;
  logic                   sys_clk, srst, spi_sck, spi_cs_n, spi_sdi;
  logic                   spi_sdo, mon_oe, en;
  mmx_pkg::mmx_route_type mon_route;
  logic [15:0]            td_mode;
  logic [31:0]            lfsr, rx;
  logic [9:0]             sel;
  logic [3:0]             k;
  int                     num_errors, comparisons, cycles;
  mmx_monitor_mux i_mmx_monitor_mux (.sys_clk(sys_clk), .srst(srst),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .mon_oe(mon_oe), .mon_route(mon_route),
    .td_mode(td_mode));
  mmx_host host_model (.sck(spi_sck), .cs_n(spi_cs_n), .sdi(spi_sdi),
    .sdo(spi_sdo));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [3:0] exp_kind(input logic [9:0] s);
    if (s[9:4] == 6'h30) return mmx_pkg::MMX_SRC_VOUT;
    if (s[9:4] == 6'h00) return mmx_pkg::MMX_SRC_SENSE;
    if (s[9:6] == 4'h8 && s[3:0] == 4'h0) return mmx_pkg::MMX_SRC_NODE;
    return mmx_pkg::MMX_SRC_NONE;
  endfunction : exp_kind
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_lfsr
  task automatic check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    srst = 1'b1;
    lfsr = 32'h0e92;
    repeat (20) @(posedge sys_clk);
    #0.5 srst = 1'b0;
    repeat (4) @(posedge sys_clk);
    // Keeps every later pin change off the rising edge of the clock.
    #0.5;
    check("mon_oe", mon_oe, 32'h0);
    check("td_mode", td_mode, 32'h0);
    host_model.xfer(32'h1d00_0000, 24, rx);
    host_model.xfer(32'h0, 32, rx);
    check("reset readback", rx, 32'h7500_0000);
    for (int i = 0; i < 16; i++)
    begin
      lfsr = next_lfsr(lfsr);
      en = lfsr[9];
      case (lfsr[1:0])
        2'h0: sel = {6'h30, lfsr[7:4]};
        2'h1: sel = {6'h00, lfsr[7:4]};
        2'h2: sel = {4'h8, lfsr[5:4], 4'h0};
        default: sel = lfsr[17:8];
      endcase
      host_model.xfer({8'h75, lfsr[15:11], en, sel, lfsr[23:16]},
                      i[0] ? 24 : 32, rx);
      // A 20-bit frame must leave the register alone.
      host_model.xfer({8'h75, ~lfsr[23:0]}, 20, rx);
      k = exp_kind(sel);
      check("mon_oe", mon_oe, en && k != 4'h1);
      check("drive", mon_route.drive, en && k != 4'h1);
      if (en) check("kind", mon_route.kind, k);
      if (en && k[2:1] != 2'h0) check("ch", mon_route.channel, sel[3:0]);
      if (en && k == 4'h8) check("node", mon_route.node, sel[5:4]);
      host_model.xfer(32'h1d00_0000, 32, rx);
      host_model.xfer(32'h0, 32, rx);
      check("readback", rx, {8'h75, 5'h0, en, sel, 8'h0});
      host_model.xfer({8'h0b, lfsr[31:16], 8'h0}, 32, rx);
      check("td_mode", td_mode, lfsr[31:16]);
      host_model.xfer(32'h1b00_0000, 24, rx);
      host_model.xfer(32'h0, 24, rx);
      check("td readback", rx, {8'h0b, lfsr[31:16]});
    end
    finish_test();
  end
endmodule : tb_mmx_monitor_mux
